// file: rtl/compute_request_bit_pkg.sv
package compute_request_bit_pkg;
    localparam int CLK_MHZ = 100;
    localparam int CRC_W = 16;
    localparam int ID_W = 96;
    localparam int CHAL_W = 32;
    localparam int MSG_W = ID_W + CHAL_W;
    localparam logic [7:0] MSG_LAST = 8'h7F;
    localparam int OTP_GEN_N = 16;
    localparam int OTP_COMPUTE_REQUEST_BIT_N = 32;
    localparam int OTP_N = OTP_GEN_N + OTP_COMPUTE_REQUEST_BIT_N;
    localparam int OTP_AW = 6;
    localparam logic [5:0] OTP_SEED_LO = 6'h00;
    localparam logic [5:0] OTP_SEED_HI = 6'h01;
    localparam logic [5:0] OTP_POLY_LO = 6'h02;
    localparam logic [5:0] OTP_POLY_HI = 6'h03;
    localparam logic [5:0] OTP_ID_BASE = 6'h04;
    localparam int ID_BYTES = 12;
    localparam logic [7:0] OTP_CLEAR = 8'h00;
    // write to pulse, and pulse width, in microseconds
    localparam int WRITE_TO_PULSE_DELAY_US = 2;
    localparam int PROGRAM_PULSE_TIME_US = 300;
    localparam int WRITE_TO_PULSE_CYC = WRITE_TO_PULSE_DELAY_US * CLK_MHZ;
    localparam int PROGRAM_PULSE_CYC = PROGRAM_PULSE_TIME_US * CLK_MHZ;
    localparam int BREAK_TIME_US = 190;
    localparam int BREAK_CYC = BREAK_TIME_US * CLK_MHZ;
    localparam logic [1:0] BREAKS_TO_EXIT = 2'h3;
    localparam logic [4:0] FWD_BITS = 5'h10;
    localparam logic [15:0] CRC_ZERO = 16'h0000;
endpackage

// file: rtl/compute_request_bit_link_if.sv
`timescale 1ns/1ps
interface compute_request_bit_link_if;
    logic line_host_out;
    logic line_host_oe;
    logic line_dev_out;
    logic line_dev_oe;
    logic line_level;
    logic hv_pulse;
    logic down_level;
    assign line_level = !((line_host_oe && !line_host_out) ||
        (line_dev_oe && !line_dev_out));
    modport dev (
        input line_level,
        input hv_pulse,
        output line_dev_out,
        output line_dev_oe,
        input down_level
    );
    modport host (
        input line_level,
        output line_host_out,
        output line_host_oe,
        output hv_pulse
    );
endinterface

// file: rtl/crc_engine.sv
`timescale 1ns/1ps
module crc_engine
    import compute_request_bit_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic start_in,
    input wire logic [CRC_W-1:0] seed_in,
    input wire logic [CRC_W-1:0] poly_in,
    input wire logic [MSG_W-1:0] msg_in,
    output logic busy_out,
    output logic done_out,
    output logic [CRC_W-1:0] result_out
);
    logic [CRC_W-1:0] crc_q;
    logic [MSG_W-1:0] msg_q;
    logic [7:0] cnt_q;
    logic busy_q;
    logic [CRC_W-1:0] taps;
    logic [CRC_W-1:0] step;

    // x^0 coefficient is the top bit, forced; bit 15-n maps x^n
    assign taps = {1'b1, poly_in[CRC_W-2:0]};
    always_comb begin
        if (crc_q[0] ^ msg_q[0]) begin
            step = (crc_q >> 1) ^ taps;
        end else begin
            step = crc_q >> 1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
            crc_q <= CRC_ZERO;
            msg_q <= '0;
        end else if (start_in && !busy_q) begin
            busy_q <= 1'b1;
            cnt_q <= 8'h00;
            crc_q <= seed_in;
            msg_q <= msg_in; // lsb of challenge first
        end else if (busy_q) begin
            crc_q <= step;
            msg_q <= msg_q >> 1;
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == MSG_LAST) begin
                busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            done_out <= 1'b0;
            result_out <= CRC_ZERO;
        end else begin
            done_out <= busy_q && cnt_q == MSG_LAST;
            if (busy_q && cnt_q == MSG_LAST) begin
                result_out <= step;
            end
        end
    end
    assign busy_out = busy_q;
endmodule

// file: rtl/compute_request_bit_device.sv
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module compute_request_bit_device
    import compute_request_bit_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic srst_in,
    compute_request_bit_link_if.dev link,
    input wire logic [7:0] ow_bit_valid_in,
    input wire logic otp_wr_in,
    input wire logic [OTP_AW-1:0] otp_addr_in,
    input wire logic [7:0] otp_data_in,
    input wire logic [OTP_AW-1:0] otp_rd_addr_in,
    input wire logic [CHAL_W-1:0] challenge_in,
    input wire logic compute_request_bit_in,
    input wire logic continuous_forward_set_in,
    input wire logic single_forward_set_in,
    input wire logic host_bit_in,
    input wire logic down_reading_in,
    output logic [7:0] otp_rd_data_out,
    output logic compute_request_bit_out,
    output logic done_out,
    output logic [CRC_W-1:0] compute_request_bit_result_register_out,
    output logic continuous_forward_flag_out,
    output logic single_forward_flag_out,
    output logic downstream_line_out,
    output logic downstream_line_oe_out,
    output logic break_seen_out
);
    logic [7:0] otp_q [OTP_N];
    logic [7:0] pend_data_q;
    logic [OTP_AW-1:0] pend_addr_q;
    logic pend_q;
    logic [15:0] pend_wait_q;
    logic [15:0] hv_cnt_q;
    logic [15:0] low_cnt_q;
    logic brk_q;
    logic brk_pulse;
    logic [1:0] brk_run_q;
    logic [4:0] fwd_cnt_q;
    logic host_q;
    logic eng_go;
    logic eng_busy;
    logic eng_done;
    logic [CRC_W-1:0] eng_res;
    logic [ID_W-1:0] dev_id;
    logic fwd_on;

    // otp array, cleared image
    genvar gi;
    generate
        for (gi = 0; gi < ID_BYTES; gi++) begin : g_id
            assign dev_id[gi*8 +: 8] = otp_q[OTP_ID_BASE + gi];
        end
    endgenerate

    // write arms pending byte; commit only on long hv pulse
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            pend_q <= 1'b0;
            pend_addr_q <= '0;
            pend_data_q <= OTP_CLEAR;
            pend_wait_q <= '0;
            hv_cnt_q <= '0;
        end else if (otp_wr_in) begin
            pend_q <= 1'b1;
            pend_addr_q <= otp_addr_in;
            pend_data_q <= otp_data_in;
            pend_wait_q <= '0;
            hv_cnt_q <= '0;
        end else if (pend_q) begin
            if (pend_wait_q < 16'(WRITE_TO_PULSE_CYC)) begin
                pend_wait_q <= pend_wait_q + 16'h0001;
            end
            // pulse is only timed once the write has settled
            if (link.hv_pulse &&
                    pend_wait_q == 16'(WRITE_TO_PULSE_CYC)) begin
                hv_cnt_q <= hv_cnt_q + 16'h0001;
            end else if (hv_cnt_q >= 16'(PROGRAM_PULSE_CYC)) begin
                pend_q <= 1'b0; // committed on pulse fall
            end else begin
                hv_cnt_q <= '0; // short pulse does nothing
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            for (int i = 0; i < OTP_N; i++) begin
                otp_q[i] <= OTP_CLEAR;
            end
        end else if (pend_q && !link.hv_pulse &&
                hv_cnt_q >= 16'(PROGRAM_PULSE_CYC) &&
                pend_addr_q < OTP_AW'(OTP_N)) begin
            otp_q[pend_addr_q] <= otp_q[pend_addr_q] | pend_data_q;
        end
    end
    // registered read, data one cycle after the address
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            otp_rd_data_out <= OTP_CLEAR;
        end else if (otp_rd_addr_in < OTP_AW'(OTP_N)) begin
            otp_rd_data_out <= otp_q[otp_rd_addr_in];
        end else begin
            otp_rd_data_out <= OTP_CLEAR;
        end
    end

    // crc engine over id:challenge
    // held off in the done cycle, else a finished request restarts
    assign eng_go = compute_request_bit_out && !eng_busy && !eng_done;
    crc_engine u_crc (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .start_in(eng_go),
        .seed_in({otp_q[OTP_SEED_HI], otp_q[OTP_SEED_LO]}),
        .poly_in({otp_q[OTP_POLY_HI], otp_q[OTP_POLY_LO]}),
        .msg_in({dev_id, challenge_in}),
        .busy_out(eng_busy),
        .done_out(eng_done),
        .result_out(eng_res)
    );

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            compute_request_bit_out <= 1'b0;
            done_out <= 1'b0;
            compute_request_bit_result_register_out <= CRC_ZERO;
        end else begin
            if (compute_request_bit_in) begin
                compute_request_bit_out <= 1'b1;
            end else if (eng_done) begin
                compute_request_bit_out <= 1'b0;
            end
            // a finish beside a new request still flags: set wins
            if (eng_done) begin
                done_out <= 1'b1;
                compute_request_bit_result_register_out <= eng_res;
            end else if (compute_request_bit_in) begin
                done_out <= 1'b0;
            end
        end
    end

    // break detection on the host line
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            low_cnt_q <= '0;
            brk_q <= 1'b0;
        end else if (link.line_level) begin
            low_cnt_q <= '0;
            brk_q <= 1'b0;
        end else if (low_cnt_q < 16'(BREAK_CYC)) begin
            low_cnt_q <= low_cnt_q + 16'h0001;
        end else begin
            brk_q <= 1'b1;
        end
    end
    assign brk_pulse = !link.line_level && !brk_q &&
        low_cnt_q == 16'(BREAK_CYC);
    assign break_seen_out = brk_q;

    // forwarding flags
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            continuous_forward_flag_out <= 1'b0;
            single_forward_flag_out <= 1'b0;
            brk_run_q <= 2'h0;
            fwd_cnt_q <= '0;
        end else if (continuous_forward_set_in || single_forward_set_in) begin
            continuous_forward_flag_out <= continuous_forward_set_in;
            single_forward_flag_out <= single_forward_set_in &&
                !continuous_forward_set_in;
            brk_run_q <= 2'h0;
            fwd_cnt_q <= '0;
        end else if (brk_pulse) begin
            if (brk_run_q + 2'h1 == BREAKS_TO_EXIT) begin
                continuous_forward_flag_out <= 1'b0;
                single_forward_flag_out <= 1'b0;
                brk_run_q <= 2'h0;
            end else begin
                brk_run_q <= brk_run_q + 2'h1;
            end
        end else if (|ow_bit_valid_in && fwd_on) begin
            brk_run_q <= 2'h0;
            if (single_forward_flag_out) begin
                if (fwd_cnt_q + 5'h01 == FWD_BITS) begin
                    single_forward_flag_out <= 1'b0;
                    fwd_cnt_q <= '0;
                end else begin
                    fwd_cnt_q <= fwd_cnt_q + 5'h01;
                end
            end
        end
    end
    assign fwd_on = continuous_forward_flag_out || single_forward_flag_out;

    // drive downstream low only when host low and not reading back
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            host_q <= 1'b1;
        end else if (fwd_on && !down_reading_in) begin
            host_q <= link.line_level && host_bit_in;
        end else begin
            host_q <= 1'b1; // idle high
        end
    end
    assign downstream_line_out = 1'b0;
    assign downstream_line_oe_out = !host_q;
    assign link.line_dev_out = 1'b1;
    assign link.line_dev_oe = down_reading_in && fwd_on && !link.down_level;
endmodule

// file: rtl/compute_request_bit_host.sv
`timescale 1ns/1ps
module compute_request_bit_host
    import compute_request_bit_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic srst_in,
    compute_request_bit_link_if.host link,
    input wire logic break_req_in,
    input wire logic program_req_in,
    output logic busy_out,
    output logic line_level_out
);
    typedef enum logic [1:0] {
        IDLE = 2'b00,
        BRK = 2'b01,
        WAIT = 2'b11,
        PULSE = 2'b10
    } host_state_type;
    host_state_type state_q;
    logic [15:0] cnt_q;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            state_q <= IDLE;
            cnt_q <= '0;
        end else begin
            unique case (state_q)
                IDLE: begin
                    cnt_q <= '0;
                    if (break_req_in) begin
                        state_q <= BRK;
                    end else if (program_req_in) begin
                        state_q <= WAIT;
                    end
                end
                BRK: begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q == 16'(BREAK_CYC)) begin
                        state_q <= IDLE;
                    end
                end
                WAIT: begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q == 16'(WRITE_TO_PULSE_CYC)) begin
                        state_q <= PULSE;
                        cnt_q <= '0;
                    end
                end
                PULSE: begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q == 16'(PROGRAM_PULSE_CYC)) begin
                        state_q <= IDLE;
                    end
                end
            endcase
        end
    end
    assign link.line_host_out = 1'b0;
    assign link.line_host_oe = state_q == BRK;
    assign link.hv_pulse = state_q == PULSE;
    assign busy_out = state_q != IDLE;
    assign line_level_out = link.line_level;
endmodule

// file: sim/compute_request_bit_link_chk.sv
`timescale 1ns/1ps
module compute_request_bit_link_chk
    import compute_request_bit_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic hv_pulse,
    input wire logic [7:0] ow_bit_valid_in,
    input wire logic compute_request_bit_out,
    input wire logic done_out,
    input wire logic continuous_forward_flag_out,
    input wire logic single_forward_flag_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (srst_in);
    logic any_bit;
    int hv_cnt_q;
    logic [4:0] bit_cnt_q;
    assign any_bit = |ow_bit_valid_in;
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || !hv_pulse)
            hv_cnt_q <= 0;
        else
            hv_cnt_q <= hv_cnt_q + 1;
    end
    // bits forwarded since the single flag went up
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || !single_forward_flag_out)
            bit_cnt_q <= 5'h00;
        else if (any_bit)
            bit_cnt_q <= bit_cnt_q + 5'h01;
    end
    sequence s_req_taken;
        $rose(compute_request_bit_out);
    endsequence
    sequence s_crc_end;
        done_out && !compute_request_bit_out;
    endsequence
    property p_crc_latency;
        s_req_taken |-> ##[126:130] s_crc_end;
    endproperty
    property p_req_hold;
        s_req_taken |-> compute_request_bit_out [*8];
    endproperty
    property p_done_clear;
        s_req_taken |-> ##[0:1] !done_out;
    endproperty
    property p_hv_width;
        $fell(hv_pulse) |-> hv_cnt_q >= PROGRAM_PULSE_CYC;
    endproperty
    property p_single_end;
        single_forward_flag_out && any_bit && bit_cnt_q == 5'h0F
            |=> !single_forward_flag_out;
    endproperty
    property p_single_keep;
        single_forward_flag_out && !continuous_forward_flag_out && any_bit
            && bit_cnt_q < 5'h0F |=> single_forward_flag_out;
    endproperty
    property p_cont_keep;
        continuous_forward_flag_out && any_bit |=> continuous_forward_flag_out;
    endproperty
    property p_rst_clear;
        $fell(srst_in) |-> !continuous_forward_flag_out
            && !single_forward_flag_out && !done_out && !compute_request_bit_out;
    endproperty
    a_crc_latency: assert property (p_crc_latency)
        else $error("crc finish time wrong");
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped early");
    a_done_clear: assert property (p_done_clear)
        else $error("done kept on new request");
    a_hv_width: assert property (p_hv_width)
        else $error("program pulse too short");
    a_single_end: assert property (p_single_end)
        else $error("single flag kept after bit 16");
    a_single_keep: assert property (p_single_keep)
        else $error("single flag lost early");
    a_cont_keep: assert property (p_cont_keep)
        else $error("continuous flag lost on a bit");
    a_rst_clear: assert property (p_rst_clear)
        else $error("flags not clear after reset");
endmodule

// file: sim/test_pack_compute_request_bit_crc_otp_passthrough.sv
`timescale 1ns/1ps
module test_pack_compute_request_bit_crc_otp_passthrough;
    import compute_request_bit_pkg::*;
    logic ref_clk_in = 1'b0, srst_in = 1'b1, otp_wr_in = 1'b0;
    logic compute_request_bit_in = 1'b0, host_bit_in = 1'b1;
    logic continuous_forward_set_in = 1'b0, single_forward_set_in = 1'b0;
    logic break_req_in = 1'b0, program_req_in = 1'b0;
    logic [7:0] ow_bit_valid_in = 8'h00, otp_data_in = 8'h00;
    logic [OTP_AW-1:0] otp_addr_in = 6'h00, otp_rd_addr_in = 6'h00;
    logic [CHAL_W-1:0] challenge_in = 32'hC3A51E0F;
    logic [7:0] otp_rd_data_out;
    logic [CRC_W-1:0] compute_request_bit_result_register_out;
    logic compute_request_bit_out, done_out, continuous_forward_flag_out;
    logic single_forward_flag_out, downstream_line_out, busy_out;
    logic downstream_line_oe_out, break_seen_out, seen, dlo;
    logic down_reading_in = 1'b0;
    int n_fail = 0, n_tests = 0, cyc = 0;
    compute_request_bit_link_if lnk();
    // pulled-up downstream wire, low only while driven
    assign lnk.down_level = !(downstream_line_oe_out && !downstream_line_out);
    compute_request_bit_device i_compute_request_bit_device(.link(lnk.dev), .*);
    compute_request_bit_host i_compute_request_bit_host(.link(lnk.host), .line_level_out(), .*);
    compute_request_bit_link_chk i_compute_request_bit_link_chk(.hv_pulse(lnk.hv_pulse), .*);
    initial forever #5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 95000) begin
            n_fail++;
            $display("unexpected at %0t: run timed out", $time);
            complete_run();
        end
    end
    task automatic complete_run();
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, exp, input string m);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    // ends just past the edge so outputs have settled
    task automatic clk(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        otp_rd_addr_in <= a;
        // read data is registered; two edges also cover a commit in flight
        clk(2);
        chk(otp_rd_data_out, e, "otp byte");
    endtask
    task automatic commit(input logic [5:0] a, input logic [7:0] d, bit hv);
        int k = 0;
        otp_addr_in <= a;
        otp_data_in <= d;
        otp_wr_in <= 1'b1;
        clk(1);
        otp_wr_in <= 1'b0;
        clk(WRITE_TO_PULSE_CYC + 50);
        if (hv) begin
            program_req_in <= 1'b1;
            clk(1);
            program_req_in <= 1'b0;
            clk(2);
            while (busy_out !== 1'b0 && k < 40000) begin
                clk(1);
                k++;
            end
            chk(k < 40000, 1'b1, "program hang");
        end
    endtask
    // seed and identifier stay cleared in this run
    function automatic logic [15:0] crc_of(input logic [15:0] p);
        logic [15:0] s = 16'h0000;
        logic [127:0] m = {96'h0, challenge_in};
        for (int i = 0; i < MSG_W; i++)
            s = (s[0] ^ m[i]) ? (s >> 1) ^ (p | 16'h8000) : s >> 1;
        return s;
    endfunction
    task automatic crc_run(input logic [15:0] p);
        int k = 0;
        compute_request_bit_in <= 1'b1;
        clk(1);
        compute_request_bit_in <= 1'b0;
        clk(1);
        chk(compute_request_bit_out, 1'b1, "request not held");
        while (done_out !== 1'b1 && k < 200) begin
            clk(1);
            k++;
        end
        chk(done_out, 1'b1, "no done");
        chk(compute_request_bit_out, 1'b0, "request kept");
        chk(compute_request_bit_result_register_out, crc_of(p), "crc value");
    endtask
    // stride of 3 cycles walks every valid line
    task automatic bits(input int n);
        repeat (n) begin
            host_bit_in <= 1'b0;
            ow_bit_valid_in <= 8'h01 << cyc[2:0];
            clk(1);
            host_bit_in <= 1'b1;
            ow_bit_valid_in <= 8'h00;
            clk(2);
        end
    endtask
    initial begin
        clk(12);
        srst_in <= 1'b0;
        for (int a = 0; a <= OTP_N; a++)
            rd(6'(a), 8'h00);
        crc_run(16'h0000);
        commit(OTP_POLY_LO, 8'h55, 1'b1);
        rd(OTP_POLY_LO, 8'h55);
        commit(OTP_POLY_HI, 8'h0F, 1'b0);
        rd(OTP_POLY_HI, 8'h00);
        commit(OTP_POLY_LO, 8'hAA, 1'b1);
        rd(OTP_POLY_LO, 8'hFF);
        crc_run(16'h00FF);
        single_forward_set_in <= 1'b1;
        clk(1);
        single_forward_set_in <= 1'b0;
        bits(15);
        chk(single_forward_flag_out, 1'b1, "single ended early");
        bits(1);
        chk(single_forward_flag_out, 1'b0, "single kept");
        chk(lnk.down_level, 1'b1, "downstream disturbed");
        continuous_forward_set_in <= 1'b1;
        single_forward_set_in <= 1'b1;
        clk(1);
        continuous_forward_set_in <= 1'b0;
        single_forward_set_in <= 1'b0;
        bits(16);
        chk(continuous_forward_flag_out, 1'b1, "continuous lost");
        chk(single_forward_flag_out, 1'b0, "single kept");
        down_reading_in <= 1'b1;
        host_bit_in <= 1'b0;
        clk(2);
        chk(lnk.down_level, 1'b1, "host low during read back");
        down_reading_in <= 1'b0;
        clk(2);
        chk(lnk.down_level, 1'b0, "host low not forwarded");
        host_bit_in <= 1'b1;
        clk(2);
        break_req_in <= 1'b1;
        clk(1);
        break_req_in <= 1'b0;
        seen = 1'b0;
        dlo = 1'b0;
        repeat (BREAK_CYC + 100) begin
            clk(1);
            seen |= (break_seen_out === 1'b1);
            dlo |= (lnk.down_level === 1'b0);
        end
        chk(seen, 1'b1, "no break");
        chk(dlo, 1'b1, "break not passed");
        chk(continuous_forward_flag_out, 1'b1, "one break ended");
        complete_run();
    end
endmodule
